// ### design/srl_pkg.sv
package srl_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h4;
  localparam logic [3:0] OFS_ALTPIN = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] ALTPIN_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // Field positions
  localparam int unsigned ALT_NQSEL_BIT = 0;
  localparam int unsigned SW_SET_BIT = 1;
  localparam int unsigned SW_RST_BIT = 0;

  // ==========================================================
  // Periodic pulse: N = 2 ** (DIV_BASE_LOG2 + select)
  localparam int unsigned DIV_SEL_W = 3;
  localparam int unsigned DIV_BASE_LOG2 = 2;
  localparam int unsigned DIV_CNT_W = 9;
  localparam int unsigned SW_PULSE_CYCLES = 1;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic latch_enable;
    logic [2:0] pulse_divider_select;
    logic true_output_enable;
    logic complement_output_enable;
    logic software_set_pulse;
    logic software_reset_pulse;
  } srl_ctrl0_t;

  typedef struct packed {
    logic pin_set_enable;
    logic clock_set_enable;
    logic cmp_two_set_enable;
    logic cmp_one_set_enable;
    logic pin_reset_enable;
    logic clock_reset_enable;
    logic cmp_two_reset_enable;
    logic cmp_one_reset_enable;
  } srl_ctrl1_t;

  typedef struct packed {
    logic [1:0] spare;
    logic reset_active;
    logic set_active;
    logic ext_input;
    logic cmp_two;
    logic cmp_one;
    logic latch_q;
  } srl_status_t;

endpackage

// ### design/srl_latch_cell.sv
`timescale 1ns/10ps
// Clockless reset-dominant SR storage; no reset, state is unknown until
// the first set or reset arrives.
module srl_latch_cell
(
  input wire logic set_in,
  input wire logic reset_in,
  output logic q,
  output logic q_n
);

  // ==========================================================
  // Storage
  always_latch
  begin
    if (reset_in)
    begin
      q <= 1'b0;
    end
    else if (set_in)
    begin
      q <= 1'b1;
    end
  end

  assign q_n = ~q;

endmodule

// ### design/srl_pulse_gen.sv
`timescale 1ns/10ps
module srl_pulse_gen
#(
  parameter int unsigned SEL_W = srl_pkg::DIV_SEL_W,
  parameter int unsigned CNT_W = srl_pkg::DIV_CNT_W
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [SEL_W-1:0] pulse_divider_select,
  output logic periodic_pulse
);

  // ==========================================================
  // Elaboration check
  if (CNT_W < srl_pkg::DIV_BASE_LOG2 + (1 << SEL_W) - 1)
  begin : g_bad_width
    $error("srl_pulse_gen: counter too narrow for largest divider");
  end

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] last_count;
  logic periodic_pulse_ff;

  // Last count of period; a shorter select mid-period wraps at once if the count is already at or past its new end
  always_comb
  begin
    last_count = CNT_W'((32'd1 << (srl_pkg::DIV_BASE_LOG2 + 32'(pulse_divider_select))) - 32'd1);
  end

  // ==========================================================
  // Divider
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      count_ff <= '0;
    end
    else if (count_ff >= last_count)
    begin
      count_ff <= '0; // see R6
    end
    else
    begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      periodic_pulse_ff <= 1'b0;
    end
    else
    begin
      periodic_pulse_ff <= (count_ff >= last_count); // see R6
    end
  end

  assign periodic_pulse = periodic_pulse_ff;

endmodule

// ### design/srl_top.sv
// What this block does
// R1: The latch is level-sensitive storage that changes without any clock, with active-high set and reset.
// R2: When set and reset are high together the latch goes to reset.
// R3: All set sources are ORed into one set input and all reset sources into one reset input.
// R4: Writing one to the software set or reset bit pulses that latch input for one clock; zero does nothing.
// R5: The software set and reset bits clear themselves after the pulse and always read as zero.
// R6: The periodic pulse is one cycle wide once every 4, 8, 16 ... 512 cycles as the 3-bit divider selects.
// R7: The periodic pulse sets the latch only with the clock-set enable and resets it only with the clock-reset enable.
// R8: Comparator sources are the comparators' already synchronised outputs.
// R9: With the latch enable low neither latch output reaches a pin.
// R10: With the latch enabled the true-output enable routes the true output to its pin.
// R11: With the latch enabled the complement-output enable routes the inverted output to its pin.
// R12: True and complement outputs may drive their pins at the same time.
// R13: The complement output goes to its default or alternate pin by one bit of the alternate-pin register.
// R14: Software must clear the port direction bit before a latch output actually drives its pin.
// R15: Reset leaves the latch state undefined and software must set or reset it before enabling outputs.
// R16: Separate enables gate the external pin and each comparator onto set and onto reset, acting on high level.
`timescale 1ns/10ps
module srl_top
#(
  parameter int unsigned DIV_SEL_W = srl_pkg::DIV_SEL_W,
  parameter int unsigned DIV_CNT_W = srl_pkg::DIV_CNT_W
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_latch_input,
  input wire logic cmp_one_synced_output,
  input wire logic cmp_two_synced_output,
  output logic true_output_pin,
  output logic true_output_pin_oe,
  output logic complement_output_pin,
  output logic complement_output_pin_oe,
  output logic complement_alt_pin,
  output logic complement_alt_pin_oe
);

  // ==========================================================
  // Elaboration check
  if (DIV_SEL_W != srl_pkg::DIV_SEL_W)
  begin : g_bad_sel
    $error("srl_top: divider select must stay 3 bits wide");
  end

  if (DIV_CNT_W < srl_pkg::DIV_BASE_LOG2 + (1 << DIV_SEL_W) - 1)
  begin : g_bad_cnt
    $error("srl_top: divider counter too narrow for the longest period");
  end

  if (srl_pkg::SW_SET_BIT == srl_pkg::SW_RST_BIT || srl_pkg::SW_SET_BIT > 7 || srl_pkg::SW_RST_BIT > 7)
  begin : g_bad_fields
    $error("srl_top: software pulse bits must be two distinct bits of the low byte");
  end

  // ==========================================================
  // Declarations
  srl_pkg::srl_ctrl0_t ctrl0_ff;
  srl_pkg::srl_ctrl1_t ctrl1_ff;
  logic [7:0] altpin_ff;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic sw_set_pulse_ff;
  logic sw_reset_pulse_ff;
  logic q_meta_ff;
  logic q_sync_ff;
  logic bus_req;
  logic wr_fire;
  logic rd_capture;
  logic lane0;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic periodic_pulse;
  logic set_combined;
  logic reset_combined;
  logic latch_q;
  logic latch_q_n;
  logic complement_alternate;
  srl_pkg::srl_status_t status;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_altpin;
  logic sw_set_req;
  logic sw_reset_req;
  logic latch_live;

  // ==========================================================
  // Avalon-MM slave: one wait state per access
  // Trade: every access pays one wait state, but read data leave a flop
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_ff;
  assign lane0 = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Writes land at the edge where waitrequest is low
  assign wr_fire = avs_write & ack_ff & lane0;

  // Read data captured one edge early so it stands at the accept edge
  assign rd_capture = avs_read & ~ack_ff;

  // ==========================================================
  // Write decode; a write with lane 0 off is answered but dropped
  assign wr_ctrl0 = wr_fire && (avs_address == srl_pkg::OFS_CTRL0);
  assign wr_ctrl1 = wr_fire && (avs_address == srl_pkg::OFS_CTRL1);
  assign wr_altpin = wr_fire && (avs_address == srl_pkg::OFS_ALTPIN);

  // Only a one in a pulse bit fires; a zero leaves the input alone
  assign sw_set_req = wr_ctrl0 & wbyte[srl_pkg::SW_SET_BIT]; // see R4
  assign sw_reset_req = wr_ctrl0 & wbyte[srl_pkg::SW_RST_BIT]; // see R4

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // ==========================================================
  // Control register 0
  // Pulse bits are never stored, so they read back as zero
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl0_ff <= srl_pkg::srl_ctrl0_t'(srl_pkg::CTRL0_RST);
    end
    else if (wr_ctrl0)
    begin
      ctrl0_ff <= srl_pkg::srl_ctrl0_t'(wbyte);
      ctrl0_ff.software_set_pulse <= 1'b0; // see R5
      ctrl0_ff.software_reset_pulse <= 1'b0; // see R5
    end
  end

  // ==========================================================
  // Software pulses: one clock wide, zero writes ignored
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sw_set_pulse_ff <= 1'b0;
    end
    else
    begin
      sw_set_pulse_ff <= sw_set_req; // see R4
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      sw_reset_pulse_ff <= 1'b0;
    end
    else
    begin
      sw_reset_pulse_ff <= sw_reset_req; // see R4
    end
  end

  // ==========================================================
  // Control register 1: per-source enables
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl1_ff <= srl_pkg::srl_ctrl1_t'(srl_pkg::CTRL1_RST);
    end
    else if (wr_ctrl1)
    begin
      ctrl1_ff <= srl_pkg::srl_ctrl1_t'(wbyte); // see R16
    end
  end

  // ==========================================================
  // Alternate-pin register; only the complement select is kept
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      altpin_ff <= srl_pkg::ALTPIN_RST;
    end
    else if (wr_altpin)
    begin
      altpin_ff <= {7'h00, wbyte[srl_pkg::ALT_NQSEL_BIT]};
    end
  end

  assign complement_alternate = altpin_ff[srl_pkg::ALT_NQSEL_BIT];

  // ==========================================================
  // Periodic pulse source
  srl_pulse_gen
  #(
    .SEL_W(DIV_SEL_W),
    .CNT_W(DIV_CNT_W)
  )
  u_pulse
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pulse_divider_select(ctrl0_ff.pulse_divider_select),
    .periodic_pulse(periodic_pulse)
  );

  // ==========================================================
  // Source combining
  // Comparator inputs arrive already synchronised by the comparator
  always_comb
  begin
    set_combined = sw_set_pulse_ff // see R3
                   | (ctrl1_ff.clock_set_enable & periodic_pulse) // see R7
                   | (ctrl1_ff.pin_set_enable & external_latch_input) // see R16
                   | (ctrl1_ff.cmp_one_set_enable & cmp_one_synced_output) // see R8
                   | (ctrl1_ff.cmp_two_set_enable & cmp_two_synced_output); // see R8
  end

  always_comb
  begin
    reset_combined = sw_reset_pulse_ff // see R3
                     | (ctrl1_ff.clock_reset_enable & periodic_pulse) // see R7
                     | (ctrl1_ff.pin_reset_enable & external_latch_input) // see R16
                     | (ctrl1_ff.cmp_one_reset_enable & cmp_one_synced_output) // see R8
                     | (ctrl1_ff.cmp_two_reset_enable & cmp_two_synced_output); // see R8
  end

  // ==========================================================
  // The latch itself; not touched by nrst
  // Pulse terms come from flops and are glitch free; pin and comparator
  // terms are outside levels and pass straight through
  srl_latch_cell u_latch
  (
    .set_in(set_combined), // see R1
    .reset_in(reset_combined), // see R2
    .q(latch_q),
    .q_n(latch_q_n)
  );

  // ==========================================================
  // Latch state seen by software
  // The latch changes without the clock, so it is synchronised first;
  // until software sets or clears it after reset the status bit is unknown
  always_ff @(posedge ref_clk)
  begin
    q_meta_ff <= latch_q; // see R15
    q_sync_ff <= q_meta_ff;
  end

  always_comb
  begin
    status = '0;
    status.latch_q = q_sync_ff;
    status.cmp_one = cmp_one_synced_output;
    status.cmp_two = cmp_two_synced_output;
    status.ext_input = external_latch_input;
    status.set_active = set_combined;
    status.reset_active = reset_combined;
  end

  // ==========================================================
  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (avs_address)
      srl_pkg::OFS_CTRL0:
      begin
        rd_byte = ctrl0_ff;
        // Set-only bits: never let a stored one leak out
        rd_byte[srl_pkg::SW_SET_BIT] = 1'b0; // see R5
        rd_byte[srl_pkg::SW_RST_BIT] = 1'b0; // see R5
      end
      srl_pkg::OFS_CTRL1:
      begin
        rd_byte = ctrl1_ff;
      end
      srl_pkg::OFS_ALTPIN:
      begin
        rd_byte = altpin_ff;
      end
      srl_pkg::OFS_STATUS:
      begin
        rd_byte = status;
      end
      default:
      begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      readdata_ff <= srl_pkg::RDATA_RST;
    end
    else if (rd_capture)
    begin
      readdata_ff <= {24'h000000, rd_byte};
    end
  end

  assign avs_readdata = readdata_ff;

  // ==========================================================
  // Pin routing
  // Pin levels come straight from the latch so the clockless path is
  // kept; only the enables are registered. The port's direction bit sits
  // outside this block and must also allow driving.
  assign true_output_pin = latch_q; // see R10
  assign complement_output_pin = latch_q_n; // see R11
  assign complement_alt_pin = latch_q_n; // see R13

  // Master enable: with it low no pin is driven, whatever the others say
  assign latch_live = ctrl0_ff.latch_enable; // see R9

  // Both enables may be on together; no interlock with the true pin
  always_comb
  begin
    true_output_pin_oe = 1'b0;
    complement_output_pin_oe = 1'b0;
    complement_alt_pin_oe = 1'b0;
    if (latch_live)
    begin
      true_output_pin_oe = ctrl0_ff.true_output_enable; // see R10
      complement_output_pin_oe = ctrl0_ff.complement_output_enable & ~complement_alternate; // see R11 see R12
      complement_alt_pin_oe = ctrl0_ff.complement_output_enable & complement_alternate; // see R13
    end
  end

endmodule

// ### tb/srl_src_model.sv
`timescale 1ns/10ps
// ==========================================================
// Comparators and input pin facing the latch
module srl_src_model
(
  input wire logic ref_clk,
  input wire logic [2:0] src_req,
  input wire logic pin_direction_bit,
  input wire logic true_output_pin,
  input wire logic true_output_pin_oe,
  output logic external_latch_input,
  output logic cmp_one_synced_output,
  output logic cmp_two_synced_output,
  output logic true_pad
);
  // Port pin with a weak pull-down; its driver needs a cleared direction bit
  assign true_pad = (true_output_pin_oe && !pin_direction_bit) ? true_output_pin : 1'b0;

  initial
  begin
    external_latch_input = 1'b0;
    cmp_one_synced_output = 1'b0;
    cmp_two_synced_output = 1'b0;
  end

  // Outputs leave on a clock edge, as a synchronised comparator would
  always @(posedge ref_clk)
  begin
    external_latch_input <= src_req[0];
    cmp_one_synced_output <= src_req[1];
    cmp_two_synced_output <= src_req[2];
  end
endmodule

// ### tb/srl_top_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Port checks
module srl_top_asserts
#(
  parameter int unsigned DIV_SEL_W = 3,
  parameter int unsigned DIV_CNT_W = 9
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic external_latch_input,
  input wire logic cmp_one_synced_output,
  input wire logic cmp_two_synced_output,
  input wire logic true_output_pin,
  input wire logic true_output_pin_oe,
  input wire logic complement_output_pin,
  input wire logic complement_output_pin_oe,
  input wire logic complement_alt_pin,
  input wire logic complement_alt_pin_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  logic acc_rd;
  assign acc_rd = avs_read && !avs_waitrequest;

  a_comp_inverse:
    assert property ((true_output_pin_oe || complement_output_pin_oe) |-> complement_output_pin != true_output_pin)
    else $error("complement pin not inverse of true pin");
  a_alt_inverse:
    assert property (complement_alt_pin_oe |-> complement_alt_pin == !true_output_pin)
    else $error("alternate pin not inverse of true pin");
  a_alt_exclusive:
    assert property (!(complement_output_pin_oe && complement_alt_pin_oe))
    else $error("both complement pins enabled");
  a_oe_by_write:
    assert property ($changed({true_output_pin_oe, complement_output_pin_oe, complement_alt_pin_oe})
      |-> $past(avs_write && !avs_waitrequest))
    else $error("pin enable changed without a write");
  a_one_wait:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_first_wait:
    assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered without wait state");
  a_pulse_reads_zero:
    assert property (acc_rd && avs_address == srl_pkg::OFS_CTRL0 |-> avs_readdata[1:0] == 2'b00)
    else $error("pulse bits read nonzero");
  // Latch must be steady long enough to cross the two status flops
  a_status_q:
    assert property (acc_rd && avs_address == srl_pkg::OFS_STATUS && $past(nrst, 4)
      && $past(true_output_pin, 1) == true_output_pin && $past(true_output_pin, 2) == true_output_pin
      && $past(true_output_pin, 3) == true_output_pin && $past(true_output_pin, 4) == true_output_pin
      |-> avs_readdata[0] == true_output_pin)
    else $error("status latch bit differs from pin");
endmodule

bind srl_top srl_top_asserts #(.DIV_SEL_W(DIV_SEL_W), .DIV_CNT_W(DIV_CNT_W)) chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .external_latch_input(external_latch_input),
  .cmp_one_synced_output(cmp_one_synced_output), .cmp_two_synced_output(cmp_two_synced_output),
  .true_output_pin(true_output_pin), .true_output_pin_oe(true_output_pin_oe),
  .complement_output_pin(complement_output_pin), .complement_output_pin_oe(complement_output_pin_oe),
  .complement_alt_pin(complement_alt_pin), .complement_alt_pin_oe(complement_alt_pin_oe));

// ### tb/srl_top_bench.sv
`timescale 1ns/10ps
module srl_top_bench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] src_req = 3'h0;
  logic pin_dir = 1'b1;
  logic pad;
  logic ext_in, cmp1, cmp2, q, q_oe, nq, nq_oe, nqa, nqa_oe;
  logic [31:0] rdv;
  logic [7:0] sen [3] = '{8'h80, 8'h10, 8'h20};
  logic [7:0] ren [3] = '{8'h08, 8'h01, 8'h02};
  int n_fail = 0;
  int compares = 0;
  int t0;
  int t1;

  always #12.5 ref_clk = ~ref_clk;

  srl_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_latch_input(ext_in),
    .cmp_one_synced_output(cmp1), .cmp_two_synced_output(cmp2), .true_output_pin(q),
    .true_output_pin_oe(q_oe), .complement_output_pin(nq), .complement_output_pin_oe(nq_oe),
    .complement_alt_pin(nqa), .complement_alt_pin_oe(nqa_oe));
  srl_src_model src_u (.ref_clk(ref_clk), .src_req(src_req), .pin_direction_bit(pin_dir),
    .true_output_pin(q), .true_output_pin_oe(q_oe), .external_latch_input(ext_in),
    .cmp_one_synced_output(cmp1), .cmp_two_synced_output(cmp2), .true_pad(pad));

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one edge after release
  task automatic bus(input logic rw, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    avs_read <= !rw;
    avs_write <= rw;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
    begin
      @(posedge ref_clk);
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rdv, {24'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end

  initial
  begin
    cyc(4);
    nrst <= 1'b1;
    cyc(1);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'h1, 8'h00);
    bus(1'b1, 4'h0, 8'h8c, 4'h0);
    rd(4'h0, 8'h00);
    chk({q_oe, nq_oe, nqa_oe}, 3'b000);
    $display("reset and map test done");
    wr(4'h0, 8'h01);
    cyc(3);
    chk(q, 1'b0);
    wr(4'h0, 8'h02);
    cyc(3);
    chk({q, nq, nqa}, 3'b100);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h00);
    cyc(3);
    chk(q, 1'b1);
    wr(4'h0, 8'h03);
    cyc(3);
    chk(q, 1'b0);
    $display("software pulse test done");
    wr(4'h0, 8'h02);
    wr(4'h0, 8'h8c);
    chk({q_oe, nq_oe, nqa_oe}, 3'b110);
    chk(pad, 1'b0);
    pin_dir <= 1'b0;
    cyc(1);
    chk(pad, 1'b1);
    rd(4'h0, 8'h8c);
    wr(4'h8, 8'h01);
    chk({q_oe, nq_oe, nqa_oe}, 3'b101);
    rd(4'h8, 8'h01);
    wr(4'h0, 8'h0c);
    chk({q_oe, nq_oe, nqa_oe}, 3'b000);
    wr(4'h8, 8'h00);
    wr(4'h0, 8'h01);
    $display("output enable test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h4, sen[i]);
      src_req <= 3'(1 << i);
      cyc(3);
      chk(q, 1'b1);
      src_req <= 3'h0;
      wr(4'h4, ren[i]);
      src_req <= 3'(1 << i);
      cyc(3);
      chk(q, 1'b0);
      wr(4'h4, sen[(i + 1) % 3]);
      cyc(3);
      chk(q, 1'b0);
      src_req <= 3'h0;
    end
    wr(4'h4, 8'h00);
    src_req <= 3'h7;
    cyc(4);
    rd(4'hc, 8'h0e);
    wr(4'h4, 8'h12);
    rd(4'hc, 8'h3e);
    chk(q, 1'b0);
    $display("source test done");
    // Steady set plus periodic reset: latch drops for one cycle per period
    src_req <= 3'h2;
    wr(4'h4, 8'h14);
    for (int s = 0; s < 8; s++)
    begin
      wr(4'h0, 8'(s * 16));
      t0 = 0;
      while (q !== 1'b0 && t0 < 600)
      begin
        cyc(1);
        t0++;
      end
      t1 = 0;
      while (q === 1'b0 && t1 < 600)
      begin
        cyc(1);
        t1++;
      end
      chk(t1, 1);
      while (q !== 1'b0 && t1 < 1200)
      begin
        cyc(1);
        t1++;
      end
      chk(t1, 4 << s);
    end
    src_req <= 3'h0;
    wr(4'h4, 8'h40);
    wr(4'h0, 8'h01);
    cyc(8);
    chk(q, 1'b1);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'h01);
    cyc(8);
    chk(q, 1'b0);
    $display("periodic pulse test done");
    wr(4'h0, 8'h8c);
    wr(4'h4, 8'h55);
    nrst <= 1'b0;
    cyc(4);
    nrst <= 1'b1;
    cyc(1);
    chk({q_oe, nq_oe, nqa_oe}, 3'b000);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    $display("second reset test done");
    conclude();
  end
endmodule
